// [design/afbf_frame.sv]
// Actuator feedback frame assembler: builds and streams the status frame.
// Assumes sensor, motion and fault inputs come from logic on i_clock.
// A stream byte is taken at an edge where o_tx_valid and i_tx_ready are both high.
// Requests made while a frame is out merge into one later frame.
// Object reads answer one edge after the index, from values one edge old.
// Each frame is a snapshot: its fields do not change while it streams.
// Motion is locked out after a stall until the host drops its enable.
module afbf_frame
   import afbf_pkg::*;
#(
   parameter int unsigned TX_PERIOD    = TX_PERIOD_CYC,
   parameter int unsigned STALL_CYCLES = STALL_CYC
) (
   // Clock and reset
   input  wire logic                 i_clock,
   input  wire logic                 i_rst,

   // Node identity
   input  wire logic [NODE_ID_W-1:0] i_node_id,

   // Measured values
   input  wire logic [15:0]          i_position,
   input  wire logic [15:0]          i_current,
   input  wire logic [7:0]           i_speed,

   // Motion state
   input  wire logic                 i_extending,
   input  wire logic                 i_retracting,
   input  wire logic                 i_saturated,

   // Fault observation
   input  wire logic                 i_motor_driven,
   input  wire logic                 i_motion_seen,
   input  wire logic                 i_memory_corrupt,

   // Host control byte
   input  wire logic                 i_ctrl_valid,
   input  wire logic [7:0]           i_ctrl_byte,

   // Object dictionary read
   input  wire logic [15:0]          i_od_index,
   output logic [15:0]               o_od_data,
   output logic                      o_od_hit,

   // Frame stream
   input  wire logic                 i_tx_request,
   output logic                      o_tx_valid,
   input  wire logic                 i_tx_ready,
   output logic [10:0]               o_tx_cob_id,
   output logic [7:0]                o_tx_byte,
   output logic [2:0]                o_tx_byte_idx,
   output logic                      o_tx_last,

   // Motion control
   output logic                      o_motion_permit,
   output logic                      o_motion_start,
   output logic                      o_fatal_fault
);

   typedef struct packed {
      afbf_state_e         state;
      logic [PERIOD_W-1:0] period_cnt;
      logic                pending;
      logic [63:0]         frame;
      logic [2:0]          byte_idx;
      logic [10:0]         cob_id;
      logic [7:0]          tx_byte;
      logic                enable;
      logic [15:0]         position;
      logic [15:0]         current;
      logic [7:0]          speed;
      logic [7:0]          motion;
      logic [7:0]          fault;
      logic [15:0]         od_data;
      logic                od_hit;
   } afbf_frame_s;

   afbf_frame_s st_r;
   afbf_frame_s st_nxt;

   logic guard_fatal;
   logic guard_permit;
   logic guard_start;

   localparam logic [PERIOD_W-1:0] PERIOD_LIMIT = PERIOD_W'(TX_PERIOD - 1);

   // Lays the fields out, low byte of each word first
   function automatic logic [63:0] assemble(input logic [15:0] pos,
                                            input logic [15:0] cur,
                                            input logic [7:0]  spd,
                                            input logic [7:0]  mot,
                                            input logic [7:0]  err);
      logic [63:0] f;
      f = '0;
      f[7:0]   = pos[7:0];
      f[15:8]  = pos[15:8];
      f[23:16] = cur[7:0];
      f[31:24] = cur[15:8];
      f[39:32] = spd;
      f[47:40] = BYTE_UNUSED;
      f[55:48] = mot;
      f[63:56] = err;
      return f;
   endfunction

   // Picks one byte of the frame by its position
   function automatic logic [7:0] pick(input logic [63:0] f, input logic [2:0] idx);
      return f[{idx, 3'h0} +: 8];
   endfunction

   // A period tick is due when the timer reaches its limit
   function automatic logic period_due(input logic [PERIOD_W-1:0] cnt);
      return (cnt == PERIOD_LIMIT);
   endfunction

   // A frame is wanted on a host request or on a period tick
   function automatic logic frame_wanted(input logic                req,
                                         input logic [PERIOD_W-1:0] cnt);
      return req || period_due(cnt);
   endfunction

   // Streaming is under way while the sequencer sits in its send state
   function automatic logic in_send(input afbf_state_e s);
      return (s == AFBF_SEND);
   endfunction

   // The last byte of the frame is the error byte
   function automatic logic is_last(input logic [2:0] idx);
      return (idx == BYTE_LAST);
   endfunction

   // Byte position after the one just accepted
   function automatic logic [2:0] next_idx(input logic [2:0] idx);
      return idx + 3'h1;
   endfunction

   // Status frame identifier for this node
   function automatic logic [10:0] status_cob_id(input logic [NODE_ID_W-1:0] node);
      return TPDO_BASE_ID + 11'(node);
   endfunction

   // Motion byte: direction and saturation bits, the rest zero
   function automatic logic [7:0] motion_byte(input logic ext,
                                              input logic ret,
                                              input logic sat);
      logic [7:0] m;
      m                  = '0;
      m[MOT_EXTEND_BIT]  = ext;
      m[MOT_RETRACT_BIT] = ret;
      m[MOT_SAT_BIT]     = sat;
      return m;
   endfunction

   // Error byte: stall and memory faults, undefined bits zero
   function automatic logic [7:0] fault_byte(input logic fatal,
                                             input logic mem);
      logic [7:0] e;
      e                 = '0;
      e[ERR_FATAL_BIT]  = fatal;
      e[ERR_MEMORY_BIT] = mem;
      return e;
   endfunction

   // Object read decode: hit flag above the zero-extended value
   function automatic logic [16:0] od_lookup(input logic [15:0] obj,
                                             input logic [15:0] pos,
                                             input logic [15:0] cur,
                                             input logic [7:0]  spd,
                                             input logic [7:0]  mot,
                                             input logic [7:0]  err);
      logic [16:0] r;
      r = '0;
      case (obj)
         IDX_POSITION: r = {1'b1, pos};
         IDX_CURRENT:  r = {1'b1, cur};
         IDX_SPEED:    r = {1'b1, 8'h00, spd};
         IDX_MOTION:   r = {1'b1, 8'h00, mot};
         IDX_FAULT:    r = {1'b1, 8'h00, err};
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   afbf_fault_guard #(
      .STALL_CYCLES (STALL_CYCLES)
   ) u_guard (
      .i_clock        (i_clock),
      .i_rst          (i_rst),
      .i_motor_driven (i_motor_driven),
      .i_motion_seen  (i_motion_seen),
      .i_enable       (st_r.enable),
      .o_fatal        (guard_fatal),
      .o_permit       (guard_permit),
      .o_start        (guard_start)
   );

   always_comb begin
      st_nxt = st_r;

      // Host control byte carries the motion enable
      if (i_ctrl_valid) begin
         st_nxt.enable = i_ctrl_byte[CTRL_ENABLE_BIT];
      end

      // Live object values, passed through without scaling or correction
      st_nxt.position = i_position;
      st_nxt.current  = i_current;
      st_nxt.speed    = i_speed;
      st_nxt.motion   = motion_byte(i_extending, i_retracting, i_saturated);
      st_nxt.fault    = fault_byte(guard_fatal, i_memory_corrupt);

      // Object dictionary read port
      {st_nxt.od_hit, st_nxt.od_data} = od_lookup(i_od_index, st_r.position, st_r.current,
                                                  st_r.speed, st_r.motion, st_r.fault);

      // Period timer and on-demand requests queue one frame
      if (period_due(st_r.period_cnt)) begin
         st_nxt.period_cnt = '0;
      end else begin
         st_nxt.period_cnt = st_r.period_cnt + 1'b1;
      end
      if (frame_wanted(i_tx_request, st_r.period_cnt)) begin
         st_nxt.pending = 1'b1;
      end

      case (st_r.state)
         AFBF_IDLE: begin
            // Wait for a queued frame
            if (st_r.pending) begin
               st_nxt.state = AFBF_LOAD;
            end
         end

         AFBF_LOAD: begin
            // Snapshot all fields so the frame is coherent
            st_nxt.frame    = assemble(st_r.position, st_r.current, st_r.speed,
                                       st_r.motion, st_r.fault);
            st_nxt.cob_id   = status_cob_id(i_node_id);
            st_nxt.byte_idx = BYTE_FIRST;
            st_nxt.tx_byte  = pick(st_nxt.frame, BYTE_FIRST);
            // A request arriving now is kept for the next frame
            st_nxt.pending  = frame_wanted(i_tx_request, st_r.period_cnt);
            st_nxt.state    = AFBF_SEND;
         end

         AFBF_SEND: begin
            // Each byte stands until the consumer takes it
            if (i_tx_ready) begin
               if (is_last(st_r.byte_idx)) begin
                  st_nxt.state = AFBF_IDLE;
               end else begin
                  st_nxt.byte_idx = next_idx(st_r.byte_idx);
                  st_nxt.tx_byte  = pick(st_r.frame, st_nxt.byte_idx);
               end
            end
         end
         default: begin
            st_nxt.state = AFBF_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r       <= '0;
         st_r.state <= AFBF_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Object read outputs
   assign o_od_data       = st_r.od_data;
   assign o_od_hit        = st_r.od_hit;

   // Stream outputs
   assign o_tx_valid      = in_send(st_r.state);
   assign o_tx_cob_id     = st_r.cob_id;
   assign o_tx_byte       = st_r.tx_byte;
   assign o_tx_byte_idx   = st_r.byte_idx;
   assign o_tx_last       = in_send(st_r.state) && is_last(st_r.byte_idx);

   // Motion outputs
   assign o_motion_permit = guard_permit;
   assign o_motion_start  = guard_start;
   assign o_fatal_fault   = guard_fatal;

endmodule

// [design/afbf_pkg.sv]
// Package for the actuator feedback frame: indices, field layout, timing.
// Assumes a single 25 MHz clock domain shared by all users of the package.
package afbf_pkg;

   // Clock and timing
   localparam int unsigned CLOCK_HZ        = 25_000_000;
   localparam int unsigned TX_PERIOD_MS    = 100;
   localparam int unsigned STALL_TIME_MS   = 50;
   localparam int unsigned TX_PERIOD_CYC   = (CLOCK_HZ / 1000) * TX_PERIOD_MS;
   localparam int unsigned STALL_CYC       = (CLOCK_HZ / 1000) * STALL_TIME_MS;
   localparam int unsigned PERIOD_W        = 22;
   localparam int unsigned STALL_W         = 22;

   // Frame identifier
   localparam logic [10:0] TPDO_BASE_ID    = 11'h180;
   localparam int unsigned NODE_ID_W       = 7;

   // Object dictionary indices
   localparam logic [15:0] IDX_POSITION    = 16'h2200;
   localparam logic [15:0] IDX_CURRENT     = 16'h2201;
   localparam logic [15:0] IDX_SPEED       = 16'h2202;
   localparam logic [15:0] IDX_MOTION      = 16'h2204;
   localparam logic [15:0] IDX_FAULT       = 16'h2205;

   // Frame layout
   localparam int unsigned FRAME_BYTES     = 8;
   localparam logic [2:0]  BYTE_LAST       = 3'h7;
   localparam logic [2:0]  BYTE_FIRST      = 3'h0;
   localparam logic [7:0]  BYTE_UNUSED     = 8'h00;

   // Bit positions
   localparam int unsigned MOT_EXTEND_BIT  = 0;
   localparam int unsigned MOT_RETRACT_BIT = 1;
   localparam int unsigned MOT_SAT_BIT     = 2;
   localparam int unsigned ERR_FATAL_BIT   = 6;
   localparam int unsigned ERR_MEMORY_BIT  = 7;
   localparam int unsigned CTRL_ENABLE_BIT = 0;

   // Transmit sequencer states
   typedef enum logic [1:0] {
      AFBF_IDLE = 2'b00,
      AFBF_LOAD = 2'b01,
      AFBF_SEND = 2'b10
   } afbf_state_e;

endpackage

// [design/afbf_fault_guard.sv]
// Stall detection and motion lockout for the actuator feedback frame.
// Assumes drive, motion and enable inputs are synchronous to i_clock.
module afbf_fault_guard
   import afbf_pkg::*;
#(
   parameter int unsigned STALL_CYCLES = STALL_CYC
) (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst,
   // Motor observation
   input  wire logic i_motor_driven,
   input  wire logic i_motion_seen,
   // Host enable level
   input  wire logic i_enable,
   // Results
   output logic      o_fatal,
   output logic      o_permit,
   output logic      o_start
);

   typedef struct packed {
      logic [STALL_W-1:0] stall_cnt;
      logic               fatal;
      logic               lockout;
      logic               permit;
      logic               start;
   } afbf_guard_s;

   afbf_guard_s st_r;
   afbf_guard_s st_nxt;

   localparam logic [STALL_W-1:0] STALL_LIMIT = STALL_W'(STALL_CYCLES - 1);

   always_comb begin
      st_nxt = st_r;
      // Driving the motor with no motion seen counts toward a stall
      if (i_motor_driven && !i_motion_seen) begin
         if (st_r.stall_cnt != STALL_LIMIT) begin
            st_nxt.stall_cnt = st_r.stall_cnt + 1'b1;
         end
      end else begin
         st_nxt.stall_cnt = '0;
      end
      // Host dropping enable releases the lockout and fault
      if (!i_enable) begin
         st_nxt.lockout = 1'b0;
         st_nxt.fatal   = 1'b0;
      end
      // A new stall wins over a release in the same cycle
      if (i_motor_driven && !i_motion_seen && st_r.stall_cnt == STALL_LIMIT) begin
         st_nxt.fatal   = 1'b1;
         st_nxt.lockout = 1'b1;
      end
      st_nxt.permit = i_enable && !st_nxt.lockout;
      st_nxt.start  = st_nxt.permit && !st_r.permit;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_fatal  = st_r.fatal;
   assign o_permit = st_r.permit;
   assign o_start  = st_r.start;

endmodule

// [verification/afbf_monitor.sv]
// Port checker for the feedback frame assembler.
// Bound onto afbf_frame; sees its ports only.
module afbf_monitor
   import afbf_pkg::*;
#(
   parameter int unsigned TX_PERIOD    = TX_PERIOD_CYC,
   parameter int unsigned STALL_CYCLES = STALL_CYC
) (
   // Clock, reset, identity
   input  wire logic                 i_clock,
   input  wire logic                 i_rst,
   input  wire logic [NODE_ID_W-1:0] i_node_id,
   // Fault inputs
   input  wire logic                 i_motor_driven,
   input  wire logic                 i_motion_seen,
   // Frame stream
   input  wire logic                 i_tx_ready,
   input  wire logic                 o_tx_valid,
   input  wire logic [10:0]          o_tx_cob_id,
   input  wire logic [7:0]           o_tx_byte,
   input  wire logic [2:0]           o_tx_byte_idx,
   input  wire logic                 o_tx_last,
   // Motion control
   input  wire logic                 o_motion_permit,
   input  wire logic                 o_motion_start,
   input  wire logic                 o_fatal_fault
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] stall_cnt_r;
   logic [31:0] idle_cnt_r;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // Consecutive stall cycles, saturating at the threshold
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) stall_cnt_r <= 32'h0;
      else if (!(i_motor_driven && !i_motion_seen)) stall_cnt_r <= 32'h0;
      else if (stall_cnt_r < STALL_CYCLES) stall_cnt_r <= stall_cnt_r + 32'h1;
   end
   // Consecutive cycles with no frame on the stream
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) idle_cnt_r <= 32'h0;
      else if (o_tx_valid) idle_cnt_r <= 32'h0;
      else idle_cnt_r <= idle_cnt_r + 32'h1;
   end
   a_period_frame: assert property (idle_cnt_r <= TX_PERIOD + 4)
      else $error("periodic frame missing");
   a_cob_id_value: assert property (o_tx_valid |->
      o_tx_cob_id == TPDO_BASE_ID + 11'(i_node_id)) else $error("cob id wrong");
   a_byte_hold: assert property (o_tx_valid && !i_tx_ready |=>
      o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_byte_idx)) else $error("byte moved");
   a_idx_step: assert property (o_tx_valid && i_tx_ready && !o_tx_last |=>
      o_tx_valid && o_tx_byte_idx == $past(o_tx_byte_idx) + 3'h1) else $error("index skip");
   a_last_seven: assert property (o_tx_valid |->
      o_tx_last == (o_tx_byte_idx == BYTE_LAST)) else $error("last misplaced");
   a_frame_end: assert property (o_tx_valid && i_tx_ready && o_tx_last |=>
      !o_tx_valid) else $error("frame overrun");
   a_unused_zero: assert property (o_tx_valid && o_tx_byte_idx == 3'h5 |->
      o_tx_byte == BYTE_UNUSED) else $error("byte 5 not zero");
   a_start_rise: assert property (
      o_motion_start == $rose(o_motion_permit)) else $error("start pulse wrong");
   a_fatal_lock: assert property (o_fatal_fault |->
      !o_motion_permit) else $error("motion during fault");
   a_stall_fatal: assert property (stall_cnt_r == STALL_CYCLES |->
      ##[0:2] o_fatal_fault) else $error("stall not flagged");
   c_frame_done: cover property (o_tx_valid && i_tx_ready && o_tx_last);
   c_start: cover property (o_motion_start);
   c_fatal: cover property ($rose(o_fatal_fault));
   c_byte_wait: cover property (o_tx_valid && !i_tx_ready);
endmodule

// [verification/afbf_host_model.sv]
// Host controller model: takes status frames, issues control bytes.
// Assumes frame stream and control pulse share the device clock.
module afbf_host_model (
   // Clock and pacing
   input  wire logic       i_clock,
   input  wire logic       i_slow,
   // Frame stream from the device
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_byte,
   input  wire logic [2:0] i_tx_byte_idx,
   input  wire logic       i_tx_last,
   output logic            o_tx_ready,
   // Received frame and control byte
   output logic [63:0]     o_frame,
   output int              o_frames,
   output logic            o_ctrl_valid,
   output logic [7:0]      o_ctrl_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_tx_ready = 1'b0;
      o_frame = 64'h0;
      o_frames = 0;
      o_ctrl_valid = 1'b0;
      o_ctrl_byte = 8'h00;
   end
   // Slow mode accepts every other cycle
   always @(posedge i_clock) begin
      o_tx_ready <= i_slow ? !o_tx_ready : 1'b1;
      if (i_tx_valid && o_tx_ready) begin
         o_frame[i_tx_byte_idx*8 +: 8] <= i_tx_byte;
         if (i_tx_last) o_frames <= o_frames + 1;
      end
   end
   // One-cycle pulse; byte lines carry junk when idle
   task automatic send_ctrl(input logic [7:0] b);
      @(posedge i_clock);
      o_ctrl_valid <= 1'b1;
      o_ctrl_byte <= b;
      @(posedge i_clock);
      o_ctrl_valid <= 1'b0;
      o_ctrl_byte <= ~b;
   endtask
endmodule

// [verification/afbf_frame_tb.sv]
// Bench for the feedback frame assembler against a host model.
// Assumes the package, design, host model and checker are compiled first.
module afbf_frame_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import afbf_pkg::*;
   localparam int unsigned STALL = 8;
   typedef struct packed {
      logic [15:0] p;
      logic [15:0] c;
      logic [7:0]  s;
      logic [3:0]  f;   // memory, saturated, retracting, extending
   } afbf_row_s;
   localparam afbf_row_s ROWS [4] = '{
      '{16'h0000, 16'h0000, 8'h00, 4'h0}, '{16'hFFFF, 16'hFFFF, 8'hFF, 4'hF},
      '{16'h03E8, 16'h0064, 8'h1E, 4'h2}, '{16'h1234, 16'hABCD, 8'h80, 4'h5}};
   logic        i_clock, i_rst, req, slow, drv, seen, mem, ext, ret, sat;
   logic [15:0] pos, cur, idx, od_data;
   logic [7:0]  spd, tx_byte, ctrl_byte;
   logic [10:0] cob;
   logic [2:0]  bidx;
   logic [NODE_ID_W-1:0] node;
   logic [63:0] frame;
   logic        od_hit, tx_valid, ready, last, permit, start, fatal, ctrl_valid;
   int          frames, fails, tests_run;
   afbf_frame #(.TX_PERIOD(50), .STALL_CYCLES(STALL)) u_afbf_frame (
      .i_clock(i_clock), .i_rst(i_rst), .i_node_id(node), .i_position(pos),
      .i_current(cur), .i_speed(spd), .i_extending(ext), .i_retracting(ret),
      .i_saturated(sat), .i_motor_driven(drv), .i_motion_seen(seen),
      .i_memory_corrupt(mem), .i_ctrl_valid(ctrl_valid), .i_ctrl_byte(ctrl_byte),
      .i_od_index(idx), .o_od_data(od_data), .o_od_hit(od_hit), .i_tx_request(req),
      .o_tx_valid(tx_valid), .i_tx_ready(ready), .o_tx_cob_id(cob), .o_tx_byte(tx_byte),
      .o_tx_byte_idx(bidx), .o_tx_last(last), .o_motion_permit(permit),
      .o_motion_start(start), .o_fatal_fault(fatal));
   afbf_host_model u_afbf_host_model (
      .i_clock(i_clock), .i_slow(slow), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
      .i_tx_byte_idx(bidx), .i_tx_last(last), .o_tx_ready(ready), .o_frame(frame),
      .o_frames(frames), .o_ctrl_valid(ctrl_valid), .o_ctrl_byte(ctrl_byte));
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   task automatic final_report();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wait_frames(input int n);
      int t;
      t = frames;
      for (int k = 0; k < 600 && frames < t + n; k++) @(posedge i_clock);
      if (frames < t + n) begin
         fails++;
         final_report();
      end
   endtask
   task automatic od(input logic [15:0] i, input logic [15:0] e, input logic h);
      @(posedge i_clock);
      idx <= i;
      repeat (4) @(posedge i_clock);
      @(negedge i_clock);
      chk16(od_data, e);
      chk16({15'h0, od_hit}, {15'h0, h});
   endtask
   task automatic ctrl_chk(input logic [7:0] b, input logic [1:0] e);
      u_afbf_host_model.send_ctrl(b);
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
      chk16({14'h0, permit, fatal}, {14'h0, e});
   endtask
   initial begin
      logic [7:0] mot, err;
      i_rst = 1'b1;
      {req, slow, drv, mem, ext, ret, sat} = 7'h00;
      seen = 1'b1;
      {pos, cur, idx} = 48'h0;
      spd = 8'h00;
      node = 7'h05;
      fails = 0;
      tests_run = 0;
      repeat (20) @(posedge i_clock);
      @(negedge i_clock);
      chk16({13'h0, tx_valid, permit, fatal}, 16'h0000);
      @(posedge i_clock);
      i_rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clock);
         {pos, cur, spd} <= {ROWS[i].p, ROWS[i].c, ROWS[i].s};
         {mem, sat, ret, ext} <= ROWS[i].f;
         slow <= i[0];
         req <= 1'b1;
         @(posedge i_clock);
         req <= 1'b0;
         wait_frames(2);
         @(negedge i_clock);
         mot = {5'h0, ROWS[i].f[2:0]};
         err = {ROWS[i].f[3], 7'h0};
         chk64(frame, {err, mot, BYTE_UNUSED, ROWS[i].s, ROWS[i].c, ROWS[i].p});
         chk16({5'h0, cob}, {5'h0, TPDO_BASE_ID + 11'(node)});
         od(IDX_POSITION, ROWS[i].p, 1'b1);
         od(IDX_CURRENT, ROWS[i].c, 1'b1);
         od(IDX_SPEED, {8'h00, ROWS[i].s}, 1'b1);
         od(IDX_MOTION, {8'h00, mot}, 1'b1);
         od(IDX_FAULT, {8'h00, err}, 1'b1);
      end
      od(16'h2203, 16'h0000, 1'b0);
      ctrl_chk(8'h01, 2'b10);
      @(posedge i_clock);
      {drv, seen} <= 2'b10;
      repeat (STALL + 4) @(posedge i_clock);
      {drv, seen} <= 2'b01;
      @(negedge i_clock);
      chk16({14'h0, permit, fatal}, 16'h0001);
      od(IDX_FAULT, 16'h0040, 1'b1);
      ctrl_chk(8'h01, 2'b01);
      ctrl_chk(8'h00, 2'b00);
      ctrl_chk(8'h01, 2'b10);
      // Reset in mid-run with a new node id
      @(posedge i_clock);
      i_rst <= 1'b1;
      node <= 7'h7F;
      repeat (3) @(posedge i_clock);
      @(negedge i_clock);
      chk16({13'h0, tx_valid, permit, fatal}, 16'h0000);
      @(posedge i_clock);
      i_rst <= 1'b0;
      wait_frames(1);
      @(negedge i_clock);
      chk16({5'h0, cob}, {5'h0, TPDO_BASE_ID + 11'(node)});
      chk64(frame, {err, mot, BYTE_UNUSED, ROWS[3].s, ROWS[3].c, ROWS[3].p});
      final_report();
   end
endmodule
bind afbf_frame afbf_monitor #(.TX_PERIOD(TX_PERIOD), .STALL_CYCLES(STALL_CYCLES))
   u_afbf_monitor (
   .i_clock(i_clock), .i_rst(i_rst), .i_node_id(i_node_id),
   .i_motor_driven(i_motor_driven), .i_motion_seen(i_motion_seen), .i_tx_ready(i_tx_ready),
   .o_tx_valid(o_tx_valid), .o_tx_cob_id(o_tx_cob_id), .o_tx_byte(o_tx_byte),
   .o_tx_byte_idx(o_tx_byte_idx), .o_tx_last(o_tx_last), .o_motion_permit(o_motion_permit),
   .o_motion_start(o_motion_start), .o_fatal_fault(o_fatal_fault));
